// [shared/iorm_map.svh]
`ifndef IORM_MAP_SVH
`define IORM_MAP_SVH
// Register offsets within the 64-entry I/O space.
`define IORM_ADC_CONTROL_B 6'h03
`define IORM_CONVERSION_RESULT_LOW 6'h04
`define IORM_CONVERSION_RESULT_HIGH 6'h05
`define IORM_CONVERTER_CONTROL_STATUS 6'h06
`define IORM_CONVERTER_INPUT_SELECT 6'h07
`define IORM_COMPARATOR_CONTROL_STATUS 6'h08
`define IORM_SERIAL_UNIT_CONTROL 6'h0d
`define IORM_SERIAL_UNIT_STATUS 6'h0e
`define IORM_SERIAL_UNIT_SHIFT_DATA 6'h0f
`define IORM_SERIAL_UNIT_BUFFER 6'h10
`define IORM_GENERAL_PURPOSE_STORE_0 6'h11
`define IORM_GENERAL_PURPOSE_STORE_1 6'h12
`define IORM_GENERAL_PURPOSE_STORE_2 6'h13
`define IORM_DIGITAL_INPUT_DISABLE 6'h14
`define IORM_PIN_CHANGE_MASK 6'h15
`define IORM_PORT_B_PIN_LEVELS 6'h16
`define IORM_PORT_B_DIRECTION 6'h17
`define IORM_PORT_B_OUTPUT_LATCH 6'h18
`define IORM_EEPROM_CONTROL 6'h1c
`define IORM_EEPROM_DATA 6'h1d
`define IORM_EEPROM_ADDRESS_LOW 6'h1e
`define IORM_EEPROM_ADDRESS_HIGH 6'h1f
`define IORM_POWER_REDUCTION 6'h20
`define IORM_WATCHDOG_CONTROL 6'h21
`define IORM_DEBUG_WIRE_DATA 6'h22
`define IORM_DEAD_TIME_PRESCALER 6'h23
`define IORM_DEAD_TIME_CHANNEL_B 6'h24
`define IORM_DEAD_TIME_CHANNEL_A 6'h25
`define IORM_CLOCK_PRESCALE 6'h26
`define IORM_PLL_CONTROL_STATUS 6'h27
`define IORM_TIMER0_COMPARE_B 6'h28
`define IORM_TIMER0_COMPARE_A 6'h29
`define IORM_TIMER0_CONTROL_A 6'h2a
`define IORM_TIMER1_COMPARE_B 6'h2b
`define IORM_GENERAL_TIMER_CONTROL 6'h2c
`define IORM_TIMER1_COMPARE_C 6'h2d
`define IORM_TIMER1_COMPARE_A 6'h2e
`define IORM_TIMER1_COUNT 6'h2f
`define IORM_TIMER1_CONTROL 6'h30
`define IORM_OSCILLATOR_CALIBRATION 6'h31
`define IORM_TIMER0_COUNT 6'h32
`define IORM_TIMER0_CONTROL_B 6'h33
`define IORM_RESET_CAUSE_STATUS 6'h34
`define IORM_CORE_CONTROL 6'h35
`define IORM_SELF_PROGRAMMING_CONTROL 6'h37
`define IORM_TIMER_INTERRUPT_FLAGS 6'h38
`define IORM_TIMER_INTERRUPT_ENABLES 6'h39
`define IORM_EXTERNAL_INTERRUPT_FLAGS 6'h3a
// Highest address that single-bit operations reach.
`define IORM_BIT_OP_LAST 6'h1f
// Implemented-bit masks for registers that hold reserved positions.
`define IORM_M_ADC_CONTROL_B 8'he7
`define IORM_M_COMPARATOR 8'hfb
`define IORM_M_SIX_LOW 8'h3f
`define IORM_M_EEPROM_ADDRESS_HIGH 8'h01
`define IORM_M_POWER_REDUCTION 8'h0f
`define IORM_M_DEAD_TIME_PRESCALER 8'h03
`define IORM_M_PLL 8'h87
`define IORM_M_CLOCK_PRESCALE 8'h8f
`define IORM_M_TIMER0_CONTROL_A 8'hf3
`define IORM_M_TIMER0_CONTROL_B 8'hcf
`define IORM_M_RESET_CAUSE 8'h0f
`define IORM_M_TIMER_FLAGS 8'h7e
`define IORM_M_EXTERNAL_FLAGS 8'h60
// Write-one-to-clear flag positions.
`define IORM_W1C_CONVERTER 8'h10
`define IORM_W1C_COMPARATOR 8'h10
`define IORM_W1C_SERIAL_STATUS 8'he0
`define IORM_W1C_WATCHDOG 8'h80
// Reset value of every stored bit.
`define IORM_RESET_VALUE 8'h00
`endif

// [shared/iorm_pkg.sv]
package iorm_pkg;
  // Access kinds issued by the core, one-hot.
  typedef enum logic [5:0] {
    IORM_OP_READ = 6'b00_0001,
    IORM_OP_WRITE = 6'b00_0010,
    IORM_SET_SINGLE_BIT_OP = 6'b00_0100,
    IORM_CLEAR_SINGLE_BIT_OP = 6'b00_1000,
    IORM_SKIP_IF_BIT_SET_OP = 6'b01_0000,
    IORM_SKIP_IF_BIT_CLEAR_OP = 6'b10_0000
  } iorm_op_t;
  // One access from the core.
  typedef struct packed {
    logic valid;
    iorm_op_t op;
    logic [5:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } iorm_req_t;
  // Answer to an access, one cycle later.
  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
    logic skip;
    logic refused;
  } iorm_rsp_t;
  // Flag-setting events from the peripherals, one byte per flag register.
  typedef struct packed {
    logic [7:0] converter;
    logic [7:0] comparator;
    logic [7:0] serial_status;
    logic [7:0] watchdog;
    logic [7:0] timer_flags;
    logic [7:0] external_flags;
  } iorm_evt_t;
  // Live values of the read-only registers fed by peripherals; the pin levels come from port_b_pins.
  typedef struct packed {
    logic [7:0] result_low;
    logic [7:0] result_high;
    logic [7:0] serial_buffer;
  } iorm_ro_t;
endpackage

// [design/iorm_bank.sv]
// Operation
// - Addresses 0x00 to 0x1F allow single-bit set and clear; higher ones refuse.
// - Addresses 0x00 to 0x1F allow testing one bit for a skip decision.
// - Status flags clear on writing one; writing zero leaves them unchanged.
// - Single-bit set or clear touches only the addressed bit; a set on a flag position clears that flag.
`timescale 1ns/1ps
`include "iorm_map.svh"
module iorm_bank
  import iorm_pkg::*;
#(
  parameter int PIN_COUNT = 6
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Core load/store port.
  input wire iorm_req_t req_i,
  output iorm_rsp_t rsp_o,
  // Peripheral side.
  input wire iorm_evt_t evt_i,
  input wire iorm_ro_t ro_i,
  input wire logic [PIN_COUNT-1:0] port_b_pins,
  // Stored register contents, one byte per address.
  output logic [63:0][7:0] regs_o
);

  // The port holds six pins; the pin register is one byte wide.
  if (PIN_COUNT < 1 || PIN_COUNT > 8) begin : g_bad_pins
    $error("PIN_COUNT must lie between 1 and 8.");
  end

  // Bits that exist at each address; zero marks a reserved position.
  function automatic logic [7:0] impl_mask(input logic [5:0] a);
    logic [7:0] m;
    m = 8'h00;
    unique case (a)
      `IORM_ADC_CONTROL_B: m = `IORM_M_ADC_CONTROL_B;
      `IORM_COMPARATOR_CONTROL_STATUS: m = `IORM_M_COMPARATOR;
      `IORM_EEPROM_CONTROL, `IORM_SELF_PROGRAMMING_CONTROL: m = `IORM_M_SIX_LOW;
      `IORM_DIGITAL_INPUT_DISABLE, `IORM_PIN_CHANGE_MASK: m = `IORM_M_SIX_LOW;
      `IORM_PORT_B_PIN_LEVELS, `IORM_PORT_B_DIRECTION: m = `IORM_M_SIX_LOW;
      `IORM_PORT_B_OUTPUT_LATCH: m = `IORM_M_SIX_LOW;
      `IORM_EEPROM_ADDRESS_HIGH: m = `IORM_M_EEPROM_ADDRESS_HIGH;
      `IORM_POWER_REDUCTION: m = `IORM_M_POWER_REDUCTION;
      `IORM_DEAD_TIME_PRESCALER: m = `IORM_M_DEAD_TIME_PRESCALER;
      `IORM_PLL_CONTROL_STATUS: m = `IORM_M_PLL;
      `IORM_CLOCK_PRESCALE: m = `IORM_M_CLOCK_PRESCALE;
      `IORM_TIMER0_CONTROL_A: m = `IORM_M_TIMER0_CONTROL_A;
      `IORM_TIMER0_CONTROL_B: m = `IORM_M_TIMER0_CONTROL_B;
      `IORM_RESET_CAUSE_STATUS: m = `IORM_M_RESET_CAUSE;
      `IORM_TIMER_INTERRUPT_FLAGS, `IORM_TIMER_INTERRUPT_ENABLES: m = `IORM_M_TIMER_FLAGS;
      `IORM_EXTERNAL_INTERRUPT_FLAGS: m = `IORM_M_EXTERNAL_FLAGS;
      `IORM_CONVERSION_RESULT_LOW, `IORM_CONVERSION_RESULT_HIGH,
      `IORM_CONVERTER_CONTROL_STATUS, `IORM_CONVERTER_INPUT_SELECT,
      `IORM_SERIAL_UNIT_CONTROL, `IORM_SERIAL_UNIT_STATUS,
      `IORM_SERIAL_UNIT_SHIFT_DATA, `IORM_SERIAL_UNIT_BUFFER,
      `IORM_GENERAL_PURPOSE_STORE_0, `IORM_GENERAL_PURPOSE_STORE_1,
      `IORM_GENERAL_PURPOSE_STORE_2, `IORM_EEPROM_DATA,
      `IORM_EEPROM_ADDRESS_LOW, `IORM_WATCHDOG_CONTROL,
      `IORM_DEBUG_WIRE_DATA, `IORM_DEAD_TIME_CHANNEL_B,
      `IORM_DEAD_TIME_CHANNEL_A, `IORM_TIMER0_COMPARE_B,
      `IORM_TIMER0_COMPARE_A, `IORM_TIMER1_COMPARE_B,
      `IORM_GENERAL_TIMER_CONTROL, `IORM_TIMER1_COMPARE_C,
      `IORM_TIMER1_COMPARE_A, `IORM_TIMER1_COUNT,
      `IORM_TIMER1_CONTROL, `IORM_OSCILLATOR_CALIBRATION,
      `IORM_TIMER0_COUNT, `IORM_CORE_CONTROL: m = 8'hff;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // Flag positions that clear when written with one.
  function automatic logic [7:0] w1c_mask(input logic [5:0] a);
    logic [7:0] m;
    m = 8'h00;
    unique case (a)
      `IORM_CONVERTER_CONTROL_STATUS: m = `IORM_W1C_CONVERTER;
      `IORM_COMPARATOR_CONTROL_STATUS: m = `IORM_W1C_COMPARATOR;
      `IORM_SERIAL_UNIT_STATUS: m = `IORM_W1C_SERIAL_STATUS;
      `IORM_WATCHDOG_CONTROL: m = `IORM_W1C_WATCHDOG;
      `IORM_TIMER_INTERRUPT_FLAGS: m = `IORM_M_TIMER_FLAGS;
      `IORM_EXTERNAL_INTERRUPT_FLAGS: m = `IORM_M_EXTERNAL_FLAGS;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // Registers whose value comes live from a peripheral or the pins.
  function automatic logic is_ro(input logic [5:0] a);
    return a == `IORM_CONVERSION_RESULT_LOW || a == `IORM_CONVERSION_RESULT_HIGH ||
           a == `IORM_SERIAL_UNIT_BUFFER || a == `IORM_PORT_B_PIN_LEVELS;
  endfunction

  // Flag-setting events routed to the register they belong to.
  function automatic logic [7:0] evt_of(input logic [5:0] a, input iorm_evt_t e);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `IORM_CONVERTER_CONTROL_STATUS: v = e.converter;
      `IORM_COMPARATOR_CONTROL_STATUS: v = e.comparator;
      `IORM_SERIAL_UNIT_STATUS: v = e.serial_status;
      `IORM_WATCHDOG_CONTROL: v = e.watchdog;
      `IORM_TIMER_INTERRUPT_FLAGS: v = e.timer_flags;
      `IORM_EXTERNAL_INTERRUPT_FLAGS: v = e.external_flags;
      default: v = 8'h00;
    endcase
    return v & w1c_mask(a);
  endfunction

  logic [PIN_COUNT-1:0] pin_meta_q;
  logic [PIN_COUNT-1:0] pin_sync_q;
  logic [63:0][7:0] store_q;
  logic bit_op;
  logic test_op;
  logic low_addr;
  logic [7:0] cur_val;
  logic [7:0] rd_data;
  logic [7:0] sel_bit;
  iorm_rsp_t rsp_d;
  iorm_rsp_t rsp_q;

  // Pins come from outside the clock domain, so they pass two flip-flops.
  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin_sync
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        pin_meta_q[p] <= 1'b0;
        pin_sync_q[p] <= 1'b0;
      end else begin
        pin_meta_q[p] <= port_b_pins[p];
        pin_sync_q[p] <= pin_meta_q[p];
      end
    end
  end

  // Decode of the current access.
  assign bit_op = req_i.valid &&
                  (req_i.op == IORM_SET_SINGLE_BIT_OP || req_i.op == IORM_CLEAR_SINGLE_BIT_OP);
  assign test_op = req_i.valid &&
                   (req_i.op == IORM_SKIP_IF_BIT_SET_OP || req_i.op == IORM_SKIP_IF_BIT_CLEAR_OP);
  assign low_addr = req_i.addr <= `IORM_BIT_OP_LAST;
  assign sel_bit = 8'h01 << req_i.bit_sel;
  assign cur_val = store_q[req_i.addr];

  // Read value: live sources for read-only registers, zero in reserved places.
  always_comb begin
    rd_data = cur_val & impl_mask(req_i.addr);
    unique case (req_i.addr)
      `IORM_CONVERSION_RESULT_LOW: rd_data = ro_i.result_low;
      `IORM_CONVERSION_RESULT_HIGH: rd_data = ro_i.result_high;
      `IORM_SERIAL_UNIT_BUFFER: rd_data = ro_i.serial_buffer;
      `IORM_PORT_B_PIN_LEVELS: rd_data = 8'(pin_sync_q) & `IORM_M_SIX_LOW;
      default: ;
    endcase
  end

  // One storage byte per address; each entry decides its own next value.
  for (genvar a = 0; a < 64; a++) begin : g_entry
    localparam logic [5:0] ADDR = 6'(a);
    localparam logic [7:0] IMPL = impl_mask(ADDR);
    localparam logic [7:0] W1C = w1c_mask(ADDR);
    localparam logic [7:0] KEEP = is_ro(ADDR) ? 8'h00 : IMPL;
    localparam logic [7:0] RW = KEEP & ~W1C;
    logic hit;
    logic [7:0] nxt_d;
    assign hit = req_i.valid && req_i.addr == ADDR;
    always_comb begin
      nxt_d = store_q[a];
      if (hit) begin
        unique case (req_i.op)
          IORM_OP_WRITE: begin
            // Flags drop only where a one is written; plain bits take the data.
            nxt_d = (store_q[a] & W1C & ~req_i.wdata) | (req_i.wdata & RW);
          end
          IORM_SET_SINGLE_BIT_OP: begin
            if (low_addr) begin
              // Setting a flag position writes one to it, which clears that flag alone.
              nxt_d = (store_q[a] & ~(sel_bit & W1C)) | (sel_bit & RW);
            end
          end
          IORM_CLEAR_SINGLE_BIT_OP: begin
            if (low_addr) begin
              // Writing zero to a flag leaves it, so only plain bits clear.
              nxt_d = store_q[a] & ~(sel_bit & RW);
            end
          end
          default: ;
        endcase
      end
      // A peripheral event in the same cycle as a clear wins.
      nxt_d = (nxt_d | evt_of(ADDR, evt_i)) & KEEP;
    end
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        store_q[a] <= `IORM_RESET_VALUE;
      end else begin
        store_q[a] <= nxt_d;
      end
    end
  end

  // Answer to the core, registered one cycle after the access.
  always_comb begin
    rsp_d = '0;
    rsp_d.valid = req_i.valid;
    if (req_i.valid) begin
      rsp_d.rdata = rd_data;
      rsp_d.refused = (bit_op || test_op) && !low_addr;
      if (test_op && low_addr) begin
        // The skip decision on the addressed bit.
        rsp_d.skip = (req_i.op == IORM_SKIP_IF_BIT_SET_OP) ?
                     rd_data[req_i.bit_sel] : !rd_data[req_i.bit_sel];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign rsp_o = rsp_q;
  assign regs_o = store_q;

  // A bit operation above the low range changes nothing and is refused.
  a_bitop_high_refused: assert property (@(posedge clk) disable iff (!arst_n)
    (bit_op && !low_addr && evt_i == '0) |=>
      rsp_o.refused && regs_o[$past(req_i.addr)] == $past(cur_val))
    else $error("Bit operation above the low range was not refused.");

  // A bit test in the low range reports the addressed bit.
  a_bit_test_skip: assert property (@(posedge clk) disable iff (!arst_n)
    (test_op && low_addr) |=> rsp_o.valid && !rsp_o.refused &&
      rsp_o.skip == ($past(req_i.op) == IORM_SKIP_IF_BIT_SET_OP ?
                     $past(rd_data[req_i.bit_sel]) : !$past(rd_data[req_i.bit_sel])))
    else $error("Bit test gave the wrong skip decision.");

  // A bit test on a stored register agrees with the byte that the bank holds.
  a_bit_test_store: assert property (@(posedge clk) disable iff (!arst_n)
    (test_op && low_addr && !is_ro(req_i.addr)) |=>
      rsp_o.skip == ($past(req_i.op) == IORM_SKIP_IF_BIT_SET_OP ?
                     $past(regs_o[req_i.addr][req_i.bit_sel]) : !$past(regs_o[req_i.addr][req_i.bit_sel])))
    else $error("Bit test disagreed with the stored bit.");

  // Writing zero to the timer flags keeps them.
  a_flag_zero_keeps: assert property (@(posedge clk) disable iff (!arst_n)
    (req_i.valid && req_i.op == IORM_OP_WRITE && req_i.addr == `IORM_TIMER_INTERRUPT_FLAGS &&
     req_i.wdata == 8'h00 && evt_i == '0) |=>
      regs_o[`IORM_TIMER_INTERRUPT_FLAGS] == $past(regs_o[`IORM_TIMER_INTERRUPT_FLAGS]))
    else $error("Writing zero changed a status flag.");

  // Writing ones to the timer flags clears them all, unless an event sets one again.
  a_flag_one_clears: assert property (@(posedge clk) disable iff (!arst_n)
    (req_i.valid && req_i.op == IORM_OP_WRITE && req_i.addr == `IORM_TIMER_INTERRUPT_FLAGS &&
     (req_i.wdata & `IORM_M_TIMER_FLAGS) == `IORM_M_TIMER_FLAGS && evt_i.timer_flags == 8'h00) |=>
      regs_o[`IORM_TIMER_INTERRUPT_FLAGS] == 8'h00)
    else $error("Writing one did not clear a status flag.");

  // A set or clear in the low range leaves every other bit as it was.
  a_bitop_only_target: assert property (@(posedge clk) disable iff (!arst_n)
    (bit_op && low_addr && evt_i == '0) |=>
      ((regs_o[$past(req_i.addr)] ^ $past(cur_val)) & ~$past(sel_bit)) == 8'h00)
    else $error("Bit operation disturbed a neighbouring bit.");

  // Reserved addresses read as zero.
  a_reserved_reads_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (req_i.valid && req_i.op == IORM_OP_READ && impl_mask(req_i.addr) == 8'h00) |=>
      rsp_o.rdata == 8'h00)
    else $error("Reserved address read as nonzero.");

endmodule

// [testbench/iorm_core_model.sv]
`timescale 1ns/1ps
module iorm_core_model
  import iorm_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Access port towards the register bank.
  output iorm_req_t req,
  input wire iorm_rsp_t rsp
);
  logic [7:0] rd;
  logic vld;
  logic skip;
  logic refused;

  // Addresses that the map leaves reserved, except 0x3B and 0x3D to 0x3F.
  function automatic logic is_reserved(input logic [5:0] a);
    return a <= 6'h02 || (a >= 6'h09 && a <= 6'h0c) || (a >= 6'h19 && a <= 6'h1b) || a == 6'h36 || a == 6'h3c;
  endfunction

  // The port is idle until the first access.
  initial begin
    req = '0;
  end

  // One access: raised after an edge, held to the taking edge, answer read just after it.
  // Callers hand over write data with reserved bit positions at zero; writes to the addresses is_reserved marks go out with valid low.
  task automatic acc(input iorm_op_t op, input logic [5:0] a, input logic [2:0] b, input logic [7:0] d);
    @(posedge clk);
    req <= '{valid: !(op == IORM_OP_WRITE && is_reserved(a)), op: op, addr: a, bit_sel: b, wdata: d};
    @(posedge clk);
    req <= '{valid: 1'b0, op: op, addr: ~a, bit_sel: ~b, wdata: ~d};
    #1;
    rd = rsp.rdata;
    vld = rsp.valid;
    skip = rsp.skip;
    refused = rsp.refused;
  endtask
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import iorm_pkg::*;
;
  logic clk;
  logic arst_n;
  iorm_req_t req;
  iorm_rsp_t rsp;
  iorm_evt_t evt;
  iorm_ro_t ro;
  logic [5:0] pins;
  logic [63:0][7:0] regs;
  logic [5:0] a;
  int bad_count;
  int checked;

  iorm_bank DUT (
    .clk(clk),
    .arst_n(arst_n),
    .req_i(req),
    .rsp_o(rsp),
    .evt_i(evt),
    .ro_i(ro),
    .port_b_pins(pins),
    .regs_o(regs)
  );

  iorm_core_model core (
    .clk(clk),
    .req(req),
    .rsp(rsp)
  );

  // Free-running 4 ns clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Compares one byte and counts it.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  // Raises peripheral events for one cycle.
  task automatic pulse(input iorm_evt_t e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
    #1;
  endtask

  // Prints the counts and the verdict.
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    arst_n = 1'b0;
    evt = '0;
    ro = '{result_low: 8'h3c, result_high: 8'h02, serial_buffer: 8'h9d};
    pins = 6'h2a;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    // Every stored byte starts at zero.
    for (int i = 0; i < 64; i++)
      chk(regs[i], 8'h00, "reset value");
    // Plain write and read back of a store.
    core.acc(IORM_OP_WRITE, 6'h11, 3'h0, 8'h5a);
    core.acc(IORM_OP_READ, 6'h11, 3'h0, 8'h00);
    chk(core.rd, 8'h5a, "store read");
    chk({7'h00, core.vld}, 8'h01, "answer valid");
    // Bit set and clear at the last bit-addressable place and the first one above it.
    core.acc(IORM_OP_WRITE, 6'h20, 3'h0, 8'h01);
    for (int i = 0; i < 2; i++) begin
      a = 6'h1f + 6'(i);
      core.acc(IORM_SET_SINGLE_BIT_OP, a, 3'h0, 8'h00);
      chk(regs[a], 8'h01, "set bit");
      chk({7'h00, core.refused}, {7'h00, i[0]}, "set refusal");
      core.acc(IORM_CLEAR_SINGLE_BIT_OP, a, 3'h0, 8'h00);
      chk(regs[a], {7'h00, i[0]}, "clear bit");
      chk({7'h00, core.refused}, {7'h00, i[0]}, "clear refusal");
    end
    // Both test kinds on a set and on a clear bit.
    core.acc(IORM_OP_WRITE, 6'h18, 3'h0, 8'h04);
    for (int i = 0; i < 4; i++) begin
      core.acc(i[0] ? IORM_SKIP_IF_BIT_CLEAR_OP : IORM_SKIP_IF_BIT_SET_OP, 6'h18, 3'(2 - i[1]), 8'h00);
      chk({7'h00, core.skip}, {7'h00, ~(i[0] ^ i[1])}, "skip decision");
    end
    // A test above the range is refused and never skips.
    core.acc(IORM_SKIP_IF_BIT_CLEAR_OP, 6'h39, 3'h0, 8'h00);
    chk({6'h00, core.skip, core.refused}, 8'h01, "test above range");
    // A test on the pin levels sees the synchronised pins.
    core.acc(IORM_SKIP_IF_BIT_SET_OP, 6'h16, 3'h5, 8'h00);
    chk({7'h00, core.skip}, 8'h01, "pin test");
    chk(core.rd, 8'h2a, "pin read");
    // Timer flags: zero leaves them, one clears only that flag.
    pulse('{timer_flags: 8'h06, default: 8'h00});
    chk(regs[6'h38], 8'h06, "flags raised");
    core.acc(IORM_OP_WRITE, 6'h38, 3'h0, 8'h00);
    chk(regs[6'h38], 8'h06, "zero write keeps flags");
    core.acc(IORM_OP_WRITE, 6'h38, 3'h0, 8'h02);
    chk(regs[6'h38], 8'h04, "one write clears flag");
    // Serial status mixes flags and plain bits.
    pulse('{serial_status: 8'he0, default: 8'h00});
    core.acc(IORM_OP_WRITE, 6'h0e, 3'h0, 8'h0f);
    chk(regs[6'h0e], 8'hef, "plain bits written, flags kept");
    core.acc(IORM_CLEAR_SINGLE_BIT_OP, 6'h0e, 3'h1, 8'h00);
    chk(regs[6'h0e], 8'hed, "clear bit leaves flags");
    core.acc(IORM_SET_SINGLE_BIT_OP, 6'h0e, 3'h5, 8'h00);
    chk(regs[6'h0e], 8'hcd, "set on a flag clears only it");
    core.acc(IORM_SET_SINGLE_BIT_OP, 6'h0e, 3'h4, 8'h00);
    chk(regs[6'h0e], 8'hdd, "set bit leaves flags");
    // The other flag registers take their own events on flag positions only.
    pulse('{converter: 8'hff, comparator: 8'hff, watchdog: 8'hff, external_flags: 8'hff, default: 8'h00});
    chk(regs[6'h06], 8'h10, "converter flag");
    chk(regs[6'h08], 8'h10, "comparator flag");
    chk(regs[6'h21], 8'h80, "watchdog flag");
    chk(regs[6'h3a], 8'h60, "external flags");
    core.acc(IORM_OP_WRITE, 6'h3a, 3'h0, 8'h60);
    chk(regs[6'h3a], 8'h00, "external flags cleared");
    core.acc(IORM_OP_WRITE, 6'h38, 3'h0, 8'h7e);
    chk(regs[6'h38], 8'h00, "all timer flags cleared");
    // Reserved and read-only places.
    core.acc(IORM_OP_READ, 6'h3c, 3'h0, 8'h00);
    chk(core.rd, 8'h00, "reserved address read");
    core.acc(IORM_OP_READ, 6'h0a, 3'h0, 8'h00);
    chk(core.rd, 8'h00, "reserved address read");
    core.acc(IORM_OP_WRITE, 6'h04, 3'h0, 8'hff);
    core.acc(IORM_OP_READ, 6'h04, 3'h0, 8'h00);
    chk(core.rd, 8'h3c, "live result read");
    core.acc(IORM_OP_READ, 6'h05, 3'h0, 8'h00);
    chk(core.rd, 8'h02, "live result high read");
    core.acc(IORM_OP_READ, 6'h10, 3'h0, 8'h00);
    chk(core.rd, 8'h9d, "live buffer read");
    core.acc(IORM_SKIP_IF_BIT_SET_OP, 6'h10, 3'h0, 8'h00);
    chk({7'h00, core.skip}, 8'h01, "buffer bit test");
    chk(regs[6'h04], 8'h00, "read-only not stored");
    end_of_test();
  end
endmodule
